// *** rtl/pte_map.svh ***
// Register map, field positions and reset values of the pulse train engine.
// Assumes inclusion from the engine's package, modules and bench.
`ifndef PTE_MAP_SVH
`define PTE_MAP_SVH
// ==========================================================================
// Geometry
`define PTE_NUM_GEN 16
// ==========================================================================
// Global register byte addresses
`define PTE_RUN_OFS 10'h000
`define PTE_STOP_OFS 10'h004
`define PTE_STAT_OFS 10'h008
`define PTE_OUT_OFS 10'h00C
// ==========================================================================
// Per generator block: address = 0x100 + 16*gen + 4*sel
`define PTE_GEN_PAGE 2'h1
`define PTE_SEL_CFG 2'h0
`define PTE_SEL_PAT 2'h1
`define PTE_SEL_LOOP 2'h2
`define PTE_SEL_RMASK 2'h3
// ==========================================================================
// Configuration word fields
`define PTE_CFG_MODE 0
`define PTE_CFG_LEN_LO 1
`define PTE_CFG_LEN_HI 5
`define PTE_CFG_DIV_LO 6
`define PTE_CFG_DIV_HI 9
`define PTE_CFG_INF 10
`define PTE_CFG_W 11
// ==========================================================================
// Reset values
`define PTE_CFG_RST 11'h03E
`define PTE_PAT_RST 32'h0000_0000
`define PTE_LOOP_RST 16'h0000
`define PTE_RMASK_RST 16'h0000
`endif

// *** rtl/pte_pkg.sv ***
// Types and shared arithmetic of the pulse train engine.
// Assumes pte_map.svh on the include path.
`include "pte_map.svh"
package pte_pkg;
  // ==========================================================================
  // Generator state
  typedef enum logic {ST_IDLE, ST_RUN} pte_state_e;
  // ==========================================================================
  // Last count of the divider for divide by 2^(k+1)
  function automatic logic [15:0] pte_div_last(input logic [3:0] k);
    pte_div_last = (16'h0002 << k) - 16'h0001;
  endfunction
  // Last bit index of a pattern, never below one (two bits minimum)
  function automatic logic [4:0] pte_last_idx(input logic [4:0] len);
    pte_last_idx = (len == 5'h00) ? 5'h01 : len;
  endfunction
endpackage

// *** rtl/pte_gen.sv ***
// One pulse train generator: divider, pattern shifter, loop counter.
// Assumes start and stop are one-cycle pulses qualified by ce.
`timescale 1ns/100ps
`include "pte_map.svh"
module pte_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic stop,
  input wire logic [`PTE_CFG_W-1:0] cfg,
  input wire logic [31:0] pattern,
  input wire logic [15:0] loops,
  output logic out_q,
  output logic running,
  output logic done_q
);
  // ==========================================================================
  // State
  pte_pkg::pte_state_e state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [4:0] idx_q, idx_d;
  logic [15:0] left_q, left_d;
  logic out_d, done_d;
  logic mode_pat, inf, tick;
  logic [4:0] last;
  logic [15:0] div_last;

  assign mode_pat = cfg[`PTE_CFG_MODE];
  assign inf = cfg[`PTE_CFG_INF];
  assign last = pte_pkg::pte_last_idx(cfg[`PTE_CFG_LEN_HI:`PTE_CFG_LEN_LO]);
  assign div_last = pte_pkg::pte_div_last(cfg[`PTE_CFG_DIV_HI:`PTE_CFG_DIV_LO]);
  assign tick = (cnt_q >= div_last);
  assign running = (state_q == pte_pkg::ST_RUN);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    left_d = left_q;
    out_d = out_q;
    done_d = 1'b0;
    // Start wins over stop so a chained restart is never swallowed
    if (start) begin
      state_d = pte_pkg::ST_RUN;
      cnt_d = 16'h0000;
      idx_d = 5'h00;
      left_d = (loops == 16'h0000) ? 16'h0001 : loops;
      out_d = mode_pat ? pattern[0] : 1'b1;
    end else if (stop) begin
      state_d = pte_pkg::ST_IDLE;
      out_d = 1'b0;
    end else if (running) begin
      cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
      if (tick) begin
        if (!mode_pat) begin
          out_d = ~out_q; // Square wave runs until stopped
        end else if (idx_q >= last) begin
          // Wrap at the end of one pass
          idx_d = 5'h00;
          out_d = pattern[0];
          if (!inf) begin
            left_d = left_q - 16'h0001;
            if (left_q <= 16'h0001) begin
              state_d = pte_pkg::ST_IDLE;
              out_d = 1'b0;
              done_d = 1'b1;
            end
          end
        end else begin
          idx_d = idx_q + 5'h01;
          out_d = pattern[idx_q + 5'h01];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= pte_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      idx_q <= 5'h00;
      left_q <= 16'h0000;
      out_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      left_q <= left_d;
      out_q <= out_d;
      done_q <= done_d;
    end
  end

  // ==========================================================================
  // Checks
  idle_low_a: assert property (@(posedge clk) disable iff (rst) !running |-> !out_q)
    else $error("idle generator output not low");
  start_run_a: assert property (@(posedge clk) disable iff (rst) ce && start |=> running)
    else $error("start did not run generator");
  stop_idle_a: assert property (@(posedge clk) disable iff (rst) ce && stop && !start |=> !running && !out_q)
    else $error("stop did not idle generator");
  div_range_a: assert property (@(posedge clk) disable iff (rst) running |-> cnt_q <= div_last || $changed(cfg))
    else $error("divider count past its limit");
  idx_range_a: assert property (@(posedge clk) disable iff (rst)
    running && mode_pat && $stable(cfg) |-> idx_q <= last)
    else $error("pattern index beyond length");
  // A pulse held by a low enable is not a second completion
  done_end_a: assert property (@(posedge clk) disable iff (rst)
    done_q && $past(ce) |-> !running && !$past(done_q))
    else $error("done without stopping");
  inf_keep_a: assert property (@(posedge clk) disable iff (rst)
    running && inf && !stop |=> running)
    else $error("indefinite repeat stopped by itself");
  pat_out_a: assert property (@(posedge clk) disable iff (rst)
    ce && running && mode_pat && tick && !start && !stop && idx_q < last
    |=> out_q == $past(pattern[idx_q + 5'h01]))
    else $error("pattern bit out of order");
  pat_cov_c: cover property (@(posedge clk) disable iff (rst) ce && running && mode_pat && tick && idx_q >= last);
  done_cov_c: cover property (@(posedge clk) disable iff (rst) done_q);
  sq_cov_c: cover property (@(posedge clk) disable iff (rst) running && !mode_pat && out_q ##1 !out_q);
endmodule

// *** rtl/pte_top.sv ***
// Pulse train engine: sixteen generators behind a plain register port.
// Assumes a single-cycle strobe master synchronous to clk; outputs go to pins.
//
// Notes on behaviour
// - Sixteen generators run independently, each driving its own output.
// - Each generator gives a square wave or a 2 to 32 bit pattern.
// - Every generator has own enable and settings; others stay unaffected.
// - Software starts generators singly or as a synchronised group.
// - Output rate is module clock divided by a chosen power of two.
// - Single shot plays the pattern once, then stops.
// - Repeat mode plays a set number of times or forever.
// - Loop count end can restart software-chosen other generators.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "pte_map.svh"
module pte_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [`PTE_NUM_GEN-1:0] pt_out
);
  // ==========================================================================
  // Configuration storage
  logic [`PTE_CFG_W-1:0] cfg_q [`PTE_NUM_GEN], cfg_d [`PTE_NUM_GEN];
  logic [31:0] pat_q [`PTE_NUM_GEN], pat_d [`PTE_NUM_GEN];
  logic [15:0] loop_q [`PTE_NUM_GEN], loop_d [`PTE_NUM_GEN];
  logic [15:0] rmask_q [`PTE_NUM_GEN], rmask_d [`PTE_NUM_GEN];
  logic [31:0] rdata_q, rdata_d;
  logic [`PTE_NUM_GEN-1:0] running, done, start_vec, stop_vec, chain_vec;
  logic gen_hit;
  logic [3:0] gsel;
  logic [1:0] rsel;

  assign gen_hit = (addr[9:8] == `PTE_GEN_PAGE);
  assign gsel = addr[7:4];
  assign rsel = addr[3:2];

  always_comb begin
    for (int g = 0; g < `PTE_NUM_GEN; g++) begin
      cfg_d[g] = cfg_q[g];
      pat_d[g] = pat_q[g];
      loop_d[g] = loop_q[g];
      rmask_d[g] = rmask_q[g];
    end
    // Each write touches one generator's word only
    if (wr && gen_hit) begin
      case (rsel)
        `PTE_SEL_CFG: cfg_d[gsel] = wdata[`PTE_CFG_W-1:0];
        `PTE_SEL_PAT: pat_d[gsel] = wdata;
        `PTE_SEL_LOOP: loop_d[gsel] = wdata[15:0];
        `PTE_SEL_RMASK: rmask_d[gsel] = wdata[15:0];
        default: cfg_d[gsel] = cfg_q[gsel];
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int g = 0; g < `PTE_NUM_GEN; g++) begin
        cfg_q[g] <= `PTE_CFG_RST;
        pat_q[g] <= `PTE_PAT_RST;
        loop_q[g] <= `PTE_LOOP_RST;
        rmask_q[g] <= `PTE_RMASK_RST;
      end
    end else if (ce) begin
      for (int g = 0; g < `PTE_NUM_GEN; g++) begin
        cfg_q[g] <= cfg_d[g];
        pat_q[g] <= pat_d[g];
        loop_q[g] <= loop_d[g];
        rmask_q[g] <= rmask_d[g];
      end
    end
  end

  // ==========================================================================
  // Start, stop and chaining
  always_comb begin
    chain_vec = '0;
    for (int g = 0; g < `PTE_NUM_GEN; g++) begin
      if (done[g]) begin
        chain_vec = chain_vec | rmask_q[g];
      end
    end
  end
  // One write starts every selected bit in the same cycle, so outputs align
  assign start_vec = ((wr && addr == `PTE_RUN_OFS) ? wdata[15:0] : 16'h0000) | chain_vec;
  // Stop is ignored by a generator that a restart selects in the same cycle
  assign stop_vec = (wr && addr == `PTE_STOP_OFS) ? wdata[15:0] : 16'h0000;

  // ==========================================================================
  // Generators
  for (genvar g = 0; g < `PTE_NUM_GEN; g++) begin : gen_pt
    pte_gen u_gen (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(start_vec[g]),
      .stop(stop_vec[g]),
      .cfg(cfg_q[g]),
      .pattern(pat_q[g]),
      .loops(loop_q[g]),
      .out_q(pt_out[g]),
      .running(running[g]),
      .done_q(done[g])
    );
  end

  // ==========================================================================
  // Read port, data in the cycle after the strobe only
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd) begin
      if (gen_hit) begin
        case (rsel)
          `PTE_SEL_CFG: rdata_d = {21'h000000, cfg_q[gsel]};
          `PTE_SEL_PAT: rdata_d = pat_q[gsel];
          `PTE_SEL_LOOP: rdata_d = {16'h0000, loop_q[gsel]};
          `PTE_SEL_RMASK: rdata_d = {16'h0000, rmask_q[gsel]};
          default: rdata_d = 32'h0000_0000;
        endcase
      end else begin
        case (addr)
          `PTE_RUN_OFS: rdata_d = {16'h0000, running};
          `PTE_STAT_OFS: rdata_d = {16'h0000, running};
          `PTE_OUT_OFS: rdata_d = {16'h0000, pt_out};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end
  assign rdata = rdata_q;

  // ==========================================================================
  // Register port checks
  // Read data lags the strobe by one cycle, so every check looks one cycle back
  // Unmapped words read zero through the default branches
  rd_zero_a: assert property (@(posedge clk) disable iff (rst)
    ce && !rd |=> rdata == 32'h0000_0000)
    else $error("read data not cleared");
  rd_cfg_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && gen_hit && rsel == `PTE_SEL_CFG |=> rdata == {21'h000000, $past(cfg_q[gsel])})
    else $error("configuration read wrong");
  rd_pat_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && gen_hit && rsel == `PTE_SEL_PAT |=> rdata == $past(pat_q[gsel]))
    else $error("pattern read wrong");
  rd_loop_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && gen_hit && rsel == `PTE_SEL_LOOP |=> rdata == {16'h0000, $past(loop_q[gsel])})
    else $error("loop count read wrong");
  rd_rmask_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && gen_hit && rsel == `PTE_SEL_RMASK |=> rdata == {16'h0000, $past(rmask_q[gsel])})
    else $error("restart mask read wrong");
  rd_run_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && addr == `PTE_RUN_OFS |=> rdata == {16'h0000, $past(running)})
    else $error("run word read wrong");
  // Stop is write-only; a read must not leak the last stop mask
  rd_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && addr == `PTE_STOP_OFS |=> rdata == 32'h0000_0000)
    else $error("stop word read not zero");
  rd_out_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && addr == `PTE_OUT_OFS |=> rdata == {16'h0000, $past(pt_out)})
    else $error("pin word read wrong");
  // A write lands in the addressed word; for configuration writes the neighbour is guarded by cfg_iso_a
  wr_cfg_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr && gen_hit && rsel == `PTE_SEL_CFG |=> cfg_q[$past(gsel)] == $past(wdata[`PTE_CFG_W-1:0]))
    else $error("configuration write lost");
  wr_pat_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr && gen_hit && rsel == `PTE_SEL_PAT |=> pat_q[$past(gsel)] == $past(wdata))
    else $error("pattern write lost");
  wr_loop_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr && gen_hit && rsel == `PTE_SEL_LOOP |=> loop_q[$past(gsel)] == $past(wdata[15:0]))
    else $error("loop count write lost");
  wr_rmask_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr && gen_hit && rsel == `PTE_SEL_RMASK |=> rmask_q[$past(gsel)] == $past(wdata[15:0]))
    else $error("restart mask write lost");

  // ==========================================================================
  // Checks
  grp_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr && addr == `PTE_RUN_OFS |=> (running & $past(wdata[15:0])) == $past(wdata[15:0]))
    else $error("group start missed a generator");
  chain_a: assert property (@(posedge clk) disable iff (rst)
    ce && (chain_vec != 16'h0000) |=> (running & $past(chain_vec)) == $past(chain_vec))
    else $error("chained restart missed");
  cfg_iso_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr && gen_hit && rsel == `PTE_SEL_CFG |=> cfg_q[$past(gsel) ^ 4'h1] == $past(cfg_q[gsel ^ 4'h1]))
    else $error("write disturbed another generator");
  rd_stat_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && addr == `PTE_STAT_OFS |=> rdata == {16'h0000, $past(running)})
    else $error("status read wrong");

  // Start wins over stop, so a stop is judged only when no restart is pending
  grp_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr && addr == `PTE_STOP_OFS && chain_vec == 16'h0000
    |=> (running & $past(wdata[15:0])) == 16'h0000 && (pt_out & $past(wdata[15:0])) == 16'h0000)
    else $error("group stop left a generator on");
  pin_idle_a: assert property (@(posedge clk) disable iff (rst)
    (pt_out & ~running) == 16'h0000)
    else $error("idle pin not low");
  // A frozen enable must hold what the pins and the bus see, not only counters
  ce_hold_a: assert property (@(posedge clk) disable iff (rst)
    !ce |=> pt_out == $past(pt_out) && rdata == $past(rdata))
    else $error("state moved with enable low");
  // Running may only begin on a write to the run word or a chained restart
  no_spont_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> (running & ~$past(running) & ~$past(start_vec)) == 16'h0000)
    else $error("generator started by itself");
  grp_cov_c: cover property (@(posedge clk) disable iff (rst) ce && wr && addr == `PTE_RUN_OFS && wdata[1:0] == 2'h3);
  chain_cov_c: cover property (@(posedge clk) disable iff (rst) ce && chain_vec != 16'h0000);
endmodule

// *** verification/pte_pin_sink.sv ***
// Pin-side model of the pulse train engine: circuitry that watches the pins.
// Assumes pins are sampled on the engine clock and never driven back.
`timescale 1ns/100ps
module pte_pin_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] pins,
  output logic [15:0][7:0] rises_q
);
  // ==========================================================================
  // Rising edge counters, one per pin, so idle pins can be proven quiet
  logic [15:0] last_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 16'h0000;
      rises_q <= '0;
    end else begin
      last_q <= pins;
      for (int i = 0; i < 16; i++) begin
        if (pins[i] && !last_q[i]) begin
          rises_q[i] <= rises_q[i] + 8'h01;
        end
      end
    end
  end
endmodule

// *** verification/test_pulse_train_engine.sv ***
// Self-checking bench of the pulse train engine over its register port.
// Assumes pte_map.svh on the include path and a pin sink on the outputs.
`timescale 1ns/100ps
`include "pte_map.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module test_pulse_train_engine;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] pt_out;
  logic [15:0][7:0] rises;
  logic [31:0] rv;
  logic [15:0] held;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  pte_top u_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pt_out(pt_out));
  pte_pin_sink u_sink (.clk(clk), .rst(rst), .pins(pt_out), .rises_q(rises));
  always #4 clk = ~clk;
  // ==========================================================================
  // Bus tasks; a read returns the word seen in the cycle after the strobe
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  function automatic logic [9:0] ga(input int g, input int sel);
    ga = 10'h100 + 10'(16 * g) + 10'(4 * sel);
  endfunction
  function automatic logic [31:0] cfgw(input logic m, input logic [4:0] len, input logic [3:0] dv, input logic inf);
    cfgw = {21'h000000, inf, dv, len, m};
  endfunction
  // ==========================================================================
  // Start one generator and follow its pin bit by bit until it goes quiet
  task automatic play(input int g, input logic [31:0] pat, input int last, input int dv, input int n);
    bus_wr(`PTE_RUN_OFS, 32'(1) << g);
    #1;
    for (int p = 0; p < n; p++) begin
      for (int i = 0; i <= last; i++) begin
        `CHK(pt_out[g], pat[i])
        repeat (2 << dv) @(posedge clk);
        #1;
      end
    end
    `CHK(pt_out[g], 1'b0)
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Ceiling is over twenty times the length of the sequence below
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    bus_rd(ga(9, 0), rv);
    `CHK(rv, 32'(`PTE_CFG_RST))
    @(posedge clk);
    #1;
    `CHK(rdata, 32'h0000_0000)
    bus_rd(ga(9, 1), rv);
    `CHK(rv, `PTE_PAT_RST)
    bus_rd(ga(9, 2), rv);
    `CHK(rv, 32'(`PTE_LOOP_RST))
    bus_rd(ga(9, 3), rv);
    `CHK(rv, 32'(`PTE_RMASK_RST))
    bus_rd(10'h040, rv);
    `CHK(rv, 32'h0000_0000)
    // Full 32 bit single shot, then a length of zero taken as two bits
    bus_wr(ga(0, 0), cfgw(1'b1, 5'h1F, 4'h0, 1'b0));
    bus_wr(ga(0, 1), 32'hA5C3_0F96);
    play(0, 32'hA5C3_0F96, 31, 0, 1);
    bus_wr(ga(1, 0), cfgw(1'b1, 5'h00, 4'h0, 1'b0));
    bus_wr(ga(1, 1), 32'h0000_0002);
    play(1, 32'h0000_0002, 1, 0, 1);
    `CHK(rises[1], 8'h01)
    // Two plays at divide by four, then chained restart of generator 3
    bus_wr(ga(3, 0), cfgw(1'b0, 5'h1F, 4'h0, 1'b0));
    bus_wr(ga(2, 0), cfgw(1'b1, 5'h01, 4'h1, 1'b0));
    bus_wr(ga(2, 1), 32'h0000_0001);
    bus_wr(ga(2, 2), 32'h0000_0002);
    bus_wr(ga(2, 3), 32'h0000_0008);
    play(2, 32'h0000_0001, 1, 1, 2);
    repeat (3) @(posedge clk);
    bus_rd(`PTE_STAT_OFS, rv);
    `CHK(rv, 32'h0000_0008)
    bus_wr(`PTE_STOP_OFS, 32'h0000_0008);
    #1;
    `CHK(pt_out[3], 1'b0)
    // Group start of two squares at divide by eight and by two
    bus_wr(ga(4, 0), cfgw(1'b0, 5'h1F, 4'h2, 1'b0));
    bus_wr(ga(5, 0), cfgw(1'b0, 5'h1F, 4'h0, 1'b0));
    bus_wr(`PTE_RUN_OFS, 32'h0000_0030);
    #1;
    `CHK(pt_out[5:4], 2'b11)
    repeat (2) @(posedge clk);
    #1;
    `CHK(pt_out[5:4], 2'b01)
    repeat (6) @(posedge clk);
    #1;
    `CHK(pt_out[5:4], 2'b10)
    // Clock enable low freezes the pins
    held = pt_out;
    @(posedge clk);
    ce <= 1'b0;
    // Odd count, so a divide-by-two square that ignored the enable ends inverted
    repeat (21) @(posedge clk);
    #1;
    `CHK(pt_out, held)
    ce <= 1'b1;
    // Endless repeat survives, stop of generators 4 and 6 leaves generator 5 running
    bus_wr(ga(6, 0), cfgw(1'b1, 5'h01, 4'h0, 1'b1));
    bus_wr(ga(6, 1), 32'h0000_0003);
    bus_wr(`PTE_RUN_OFS, 32'h0000_0040);
    repeat (40) @(posedge clk);
    bus_rd(`PTE_STAT_OFS, rv);
    `CHK(rv, 32'h0000_0070)
    bus_rd(`PTE_RUN_OFS, rv);
    `CHK(rv, 32'h0000_0070)
    bus_rd(`PTE_OUT_OFS, rv);
    `CHK(rv[6], 1'b1)
    bus_wr(`PTE_STOP_OFS, 32'h0000_0050);
    bus_rd(`PTE_STAT_OFS, rv);
    `CHK(rv, 32'h0000_0020)
    bus_wr(`PTE_STOP_OFS, 32'h0000_0020);
    bus_rd(`PTE_OUT_OFS, rv);
    `CHK(rv, 32'h0000_0000)
    `CHK(rises[15:8], 64'h0)
    end_of_test();
  end
endmodule
